// File: verilog/ppc_pkg.sv
// constants for the port phy control register bank
package ppc_pkg;
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 16;
	// register byte offsets
	localparam logic [7:0]  ADDR_BASIC  = 8'he4;
	localparam logic [7:0]  ADDR_ADVERT = 8'hec;
	localparam logic [7:0]  ADDR_CTRL   = 8'hf6;
	// control register reset value
	localparam logic [15:0] CTRL_RESET  = 16'h00ff;
	// control register field positions
	localparam int          C_LED_OFF   = 15;
	localparam int          C_TX_DIS    = 14;
	localparam int          C_RESTART   = 13;
	localparam int          C_NO_AUTOX  = 10;
	localparam int          C_FORCE_X   = 9;
	localparam int          C_AN_EN     = 7;
	localparam int          C_SPEED     = 6;
	localparam int          C_DUPLEX    = 5;
	localparam int          C_PAUSE     = 4;
	localparam int          C_100F      = 3;
	localparam int          C_100H      = 2;
	localparam int          C_10F       = 1;
	localparam int          C_10H       = 0;
	// basic control view field positions
	localparam int          B_LED_OFF   = 0;
	localparam int          B_TX_DIS    = 1;
	localparam int          B_NO_AUTOX  = 3;
	localparam int          B_FORCE_X   = 4;
	localparam int          B_DUPLEX    = 8;
	localparam int          B_RESTART   = 9;
	localparam int          B_AN_EN     = 12;
	localparam int          B_SPEED     = 13;
	// advertisement view field positions
	localparam int          A_PAUSE     = 10;
	localparam int          A_100F      = 8;
	localparam int          A_100H      = 7;
	localparam int          A_10F       = 6;
	localparam int          A_10H       = 5;
	localparam logic [4:0]  A_SELECTOR  = 5'h01;
	localparam int          LED_N       = 4;
endpackage : ppc_pkg

// File: verilog/ppc_led_blank.sv
// port led output stage with blanking
`timescale 1ns/100ps
module ppc_led_blank
	import ppc_pkg::*;
#(
	parameter int N = LED_N
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic         blank,
	input  wire logic [N-1:0] led_in,
	output logic      [N-1:0] led_out
);
	// one flop per pin; blanking forces the pin high (led off)
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_led
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b)
					led_out[gi] <= 1'b1;
				else
					led_out[gi] <= blank | led_in[gi];
			end
		end
	endgenerate
endmodule : ppc_led_blank

// File: verilog/ppc_link_resolve.sv
// resolves link speed, duplex and crossover from forcing and negotiation
`timescale 1ns/100ps
module ppc_link_resolve (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic an_enable,
	input  wire logic an_failed,
	input  wire logic an_speed_100,
	input  wire logic an_full_duplex,
	input  wire logic force_speed_100,
	input  wire logic force_full,
	input  wire logic no_auto_x,
	input  wire logic force_x,
	output logic      speed_100,
	output logic      full_duplex,
	output logic      auto_x_en,
	output logic      mdix_forced
);
	// speed: negotiated result unless negotiation is off
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			speed_100 <= 1'b1;
		else
			speed_100 <= an_enable ? an_speed_100 : force_speed_100;
	end

	// duplex: a failed negotiation falls back to the forced duplex too
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			full_duplex <= 1'b1;
		else if (an_enable && !an_failed)
			full_duplex <= an_full_duplex;
		else
			full_duplex <= force_full;
	end

	// crossover: forcing only matters when auto detection is off
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			auto_x_en   <= 1'b1;
			mdix_forced <= 1'b0;
		end else begin
			auto_x_en   <= !no_auto_x;
			mdix_forced <= no_auto_x & force_x;
		end
	end
endmodule : ppc_link_resolve

// File: verilog/ppc_port_ctrl.sv
// port phy control register with basic control and advertisement views
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module ppc_port_ctrl
	import ppc_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [DATA_W-1:0] rdata,
	input  wire logic [LED_N-1:0]  led_status,
	input  wire logic              an_failed,
	input  wire logic              an_speed_100,
	input  wire logic              an_full_duplex,
	output logic                   port_led_out3,
	output logic                   port_led_out2,
	output logic                   port_led_out1,
	output logic                   port_led_out0,
	output logic                   tx_disable,
	output logic                   an_enable,
	output logic                   an_restart,
	output logic                   auto_x_en,
	output logic                   mdix_forced,
	output logic                   link_speed_100,
	output logic                   link_full_duplex,
	output logic                   adv_pause,
	output logic                   adv_100_full,
	output logic                   adv_100_half,
	output logic                   adv_10_full,
	output logic                   adv_10_half
);
	logic [DATA_W-1:0] ctrl_reg;
	logic [DATA_W-1:0] ctrl_next;
	logic [DATA_W-1:0] rdata_next;
	logic [LED_N-1:0]  led_vec;
	logic              restart_set;

	// basic control view built from the shared storage
	function automatic logic [15:0] basic_view(input logic [15:0] c);
		logic [15:0] v;
		v = 16'h0000;
		v[B_LED_OFF]  = c[C_LED_OFF];
		v[B_TX_DIS]   = c[C_TX_DIS];
		v[B_NO_AUTOX] = c[C_NO_AUTOX];
		v[B_FORCE_X]  = c[C_FORCE_X];
		v[B_DUPLEX]   = c[C_DUPLEX];
		v[B_RESTART]  = c[C_RESTART];
		v[B_AN_EN]    = c[C_AN_EN];
		v[B_SPEED]    = c[C_SPEED];
		return v;
	endfunction : basic_view

	// advertisement view built from the shared storage
	function automatic logic [15:0] advert_view(input logic [15:0] c);
		logic [15:0] v;
		v = 16'h0000;
		v[4:0]     = A_SELECTOR;
		v[A_PAUSE] = c[C_PAUSE];
		v[A_100F]  = c[C_100F];
		v[A_100H]  = c[C_100H];
		v[A_10F]   = c[C_10F];
		v[A_10H]   = c[C_10H];
		return v;
	endfunction : advert_view

	// next storage value for each write path; the views touch only
	// their aliased bits so the other bits keep their value
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_stb) begin
			case (addr)
				ADDR_CTRL: begin
					ctrl_next = wdata;
				end
				ADDR_BASIC: begin
					ctrl_next[C_LED_OFF]  = wdata[B_LED_OFF];
					ctrl_next[C_TX_DIS]   = wdata[B_TX_DIS];
					ctrl_next[C_NO_AUTOX] = wdata[B_NO_AUTOX];
					ctrl_next[C_FORCE_X]  = wdata[B_FORCE_X];
					ctrl_next[C_DUPLEX]   = wdata[B_DUPLEX];
					ctrl_next[C_RESTART]  = wdata[B_RESTART];
					ctrl_next[C_AN_EN]    = wdata[B_AN_EN];
					ctrl_next[C_SPEED]    = wdata[B_SPEED];
				end
				ADDR_ADVERT: begin
					ctrl_next[C_PAUSE] = wdata[A_PAUSE];
					ctrl_next[C_100F]  = wdata[A_100F];
					ctrl_next[C_100H]  = wdata[A_100H];
					ctrl_next[C_10F]   = wdata[A_10F];
					ctrl_next[C_10H]   = wdata[A_10H];
				end
				default: begin
					ctrl_next = ctrl_reg;
				end
			endcase
		end
	end

	// single storage word; both views alias into it
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			ctrl_reg <= CTRL_RESET;
		else
			ctrl_reg <= ctrl_next;
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		rdata_next = 16'h0000;
		if (rd_stb) begin
			case (addr)
				ADDR_CTRL:   rdata_next = ctrl_reg;
				ADDR_BASIC:  rdata_next = basic_view(ctrl_reg);
				ADDR_ADVERT: rdata_next = advert_view(ctrl_reg);
				default:     rdata_next = 16'h0000;
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rdata <= 16'h0000;
		else
			rdata <= rdata_next;
	end

	// restart fires on a fresh one written through either view;
	// the stored bit is not self-clearing, so rewriting one retriggers
	assign restart_set = !ctrl_reg[C_RESTART] & ctrl_next[C_RESTART] |
		(wr_stb & (addr == ADDR_CTRL) & wdata[C_RESTART]) |
		(wr_stb & (addr == ADDR_BASIC) & wdata[B_RESTART]);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			an_restart <= 1'b0;
		else
			an_restart <= restart_set;
	end

	// transmitter and negotiation enables
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_disable <= 1'b0;
			an_enable  <= 1'b1;
		end else begin
			tx_disable <= ctrl_reg[C_TX_DIS];
			an_enable  <= ctrl_reg[C_AN_EN];
		end
	end

	// advertised abilities to the negotiation engine
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			adv_pause    <= 1'b1;
			adv_100_full <= 1'b1;
			adv_100_half <= 1'b1;
			adv_10_full  <= 1'b1;
			adv_10_half  <= 1'b1;
		end else begin
			adv_pause    <= ctrl_reg[C_PAUSE];
			adv_100_full <= ctrl_reg[C_100F];
			adv_100_half <= ctrl_reg[C_100H];
			adv_10_full  <= ctrl_reg[C_10F];
			adv_10_half  <= ctrl_reg[C_10H];
		end
	end

	// led stage; blanking wins over the status the leds would show
	ppc_led_blank #(
		.N (LED_N)
	) u_led (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.blank   (ctrl_reg[C_LED_OFF]),
		.led_in  (led_status),
		.led_out (led_vec)
	);

	assign port_led_out3 = led_vec[3];
	assign port_led_out2 = led_vec[2];
	assign port_led_out1 = led_vec[1];
	assign port_led_out0 = led_vec[0];

	// speed, duplex and crossover resolution
	ppc_link_resolve u_link (
		.mclk            (mclk),
		.rst_b           (rst_b),
		.an_enable       (ctrl_reg[C_AN_EN]),
		.an_failed       (an_failed),
		.an_speed_100    (an_speed_100),
		.an_full_duplex  (an_full_duplex),
		.force_speed_100 (ctrl_reg[C_SPEED]),
		.force_full      (ctrl_reg[C_DUPLEX]),
		.no_auto_x       (ctrl_reg[C_NO_AUTOX]),
		.force_x         (ctrl_reg[C_FORCE_X]),
		.speed_100       (link_speed_100),
		.full_duplex     (link_full_duplex),
		.auto_x_en       (auto_x_en),
		.mdix_forced     (mdix_forced)
	);

	// blanking reaches all four pins one edge later and holds
	a_led_blank_high: assert property (@(posedge mclk) disable iff (!rst_b)
		ctrl_reg[C_LED_OFF] |=> (led_vec == 4'hf))
		else $error("led pins not high while blanked");

	// with blanking off the pins follow the status one edge later
	a_led_follow: assert property (@(posedge mclk) disable iff (!rst_b)
		!ctrl_reg[C_LED_OFF] |=> (led_vec == $past(led_status)))
		else $error("led pins do not follow status");

	// a control write of bit 14 shows at the transmitter two edges later
	a_tx_disable: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_CTRL) |-> ##2
		(tx_disable == $past(wdata[C_TX_DIS], 2)))
		else $error("transmit disable does not follow write");

	// writing one to restart through the basic view pulses the engine
	a_restart_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_BASIC && wdata[B_RESTART]) |=>
		(an_restart && ctrl_reg[C_RESTART]))
		else $error("restart pulse or stored bit missing");

	// crossover is forced only with auto detection off and bit 9 set
	a_mdix_force: assert property (@(posedge mclk) disable iff (!rst_b)
		##1 (mdix_forced == $past(ctrl_reg[C_NO_AUTOX] & ctrl_reg[C_FORCE_X]))
		&& (auto_x_en == !$past(ctrl_reg[C_NO_AUTOX])))
		else $error("crossover forcing wrong");

	// forced speed applies whenever negotiation is off
	a_forced_speed: assert property (@(posedge mclk) disable iff (!rst_b)
		(!ctrl_reg[C_AN_EN] && !$past(ctrl_reg[C_AN_EN])) |=>
		(link_speed_100 == $past(ctrl_reg[C_SPEED])))
		else $error("forced speed not applied");

	// a failed negotiation falls back to the forced duplex
	a_duplex_fallback: assert property (@(posedge mclk) disable iff (!rst_b)
		(ctrl_reg[C_AN_EN] && an_failed) |=>
		(link_full_duplex == $past(ctrl_reg[C_DUPLEX])))
		else $error("duplex fallback not applied");

	// a write through the advert view lands in control bits 4 to 0
	a_advert_alias: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_ADVERT) |=>
		(ctrl_reg[4:0] == {$past(wdata[A_PAUSE]), $past(wdata[A_100F]),
		$past(wdata[A_100H]), $past(wdata[A_10F]),
		$past(wdata[A_10H])}))
		else $error("advert view write not seen in control");

	// a control write is read back through the basic view with its bits moved to the basic view positions
	a_basic_alias: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_CTRL) ##1 (rd_stb && addr == ADDR_BASIC) |=>
		(rdata == basic_view($past(wdata, 2))))
		else $error("basic view does not mirror control");

	// spare bits hold what was written and never reach the other views
	a_spare_bits: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_CTRL) |=>
		(ctrl_reg[12:11] == $past(wdata[12:11]))
		&& (ctrl_reg[8] == $past(wdata[8])))
		else $error("spare bits not stored");

	// advert view bit 8 reads the 100 full ability
	a_adv_100_full: assert property (@(posedge mclk) disable iff (!rst_b)
		(rd_stb && addr == ADDR_ADVERT) |=>
		(rdata[A_100F] == $past(ctrl_reg[C_100F]))
		&& (rdata[4:0] == A_SELECTOR))
		else $error("advert view 100 full bit wrong");

	// pause and ability outputs follow storage one edge later
	a_adv_outputs: assert property (@(posedge mclk) disable iff (!rst_b)
		##1 ({adv_pause, adv_100_full, adv_100_half, adv_10_full,
		adv_10_half} == $past(ctrl_reg[4:0])))
		else $error("advertised abilities wrong");

	// read data stand only in the cycle after the strobe
	a_read_once: assert property (@(posedge mclk) disable iff (!rst_b)
		(!rd_stb) |=> (rdata == 16'h0000))
		else $error("read data outside read cycle");

	// negotiation enable follows bit 12 written through the basic view
	a_an_enable: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_BASIC) |-> ##2
		(an_enable == $past(wdata[B_AN_EN], 2)))
		else $error("negotiation enable not from basic view");

	// automatic crossover enable is the inverse of bit 10 after a control write
	a_auto_x: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_CTRL) |-> ##2
		(auto_x_en == !$past(wdata[C_NO_AUTOX], 2)))
		else $error("auto crossover enable wrong");

	// after reset the transmitter runs and no restart is pending
	a_reset_state: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(rst_b) |-> (ctrl_reg == CTRL_RESET))
		else $error("control not at reset value");

	// no restart pulse unless a control or basic view write happened
	a_restart_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
		!(wr_stb && (addr == ADDR_CTRL || addr == ADDR_BASIC)) |=>
		!an_restart)
		else $error("restart pulse without a write");

	// a one written to restart through the control view pulses too
	a_restart_ctrl: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_CTRL && wdata[C_RESTART]) |=>
		an_restart)
		else $error("restart pulse missing after control write");

	// blanking written through the control view reaches all four pins
	a_led_off_write: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_CTRL && wdata[C_LED_OFF]) |-> ##2
		(led_vec == 4'hf))
		else $error("led pins not blanked after write");

	// transmit disable written through the basic view
	a_tx_basic: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_BASIC) |-> ##2
		(tx_disable == $past(wdata[B_TX_DIS], 2)))
		else $error("transmit disable not from basic view");

	// with negotiation on the negotiated speed is used
	a_speed_negotiated: assert property (@(posedge mclk) disable iff (!rst_b)
		ctrl_reg[C_AN_EN] |=>
		(link_speed_100 == $past(an_speed_100)))
		else $error("negotiated speed not used");

	// a good negotiation sets the duplex
	a_duplex_negotiated: assert property (@(posedge mclk) disable iff (!rst_b)
		(ctrl_reg[C_AN_EN] && !an_failed) |=>
		(link_full_duplex == $past(an_full_duplex)))
		else $error("negotiated duplex not used");

	// with negotiation off the forced duplex applies
	a_forced_duplex: assert property (@(posedge mclk) disable iff (!rst_b)
		!ctrl_reg[C_AN_EN] |=>
		(link_full_duplex == $past(ctrl_reg[C_DUPLEX])))
		else $error("forced duplex not applied");

	// basic view bits without a control alias read as zero
	a_basic_hidden: assert property (@(posedge mclk) disable iff (!rst_b)
		(rd_stb && addr == ADDR_BASIC) |=>
		((rdata & 16'hcce4) == 16'h0000))
		else $error("unmapped basic view bits not zero");

	// advert view bits above the selector without a control alias read as zero
	a_advert_hidden: assert property (@(posedge mclk) disable iff (!rst_b)
		(rd_stb && addr == ADDR_ADVERT) |=>
		((rdata & 16'hfa00) == 16'h0000))
		else $error("unmapped advert view bits not zero");

	// storage only moves on a write, so spare bits hold their value
	a_store_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		!wr_stb |=> $stable(ctrl_reg))
		else $error("storage changed without a write");

	// a basic view write leaves spare and ability bits alone
	a_basic_keeps: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_stb && addr == ADDR_BASIC) |=>
		(ctrl_reg[12:11] == $past(ctrl_reg[12:11]))
		&& (ctrl_reg[8] == $past(ctrl_reg[8]))
		&& (ctrl_reg[4:0] == $past(ctrl_reg[4:0])))
		else $error("basic view write touched other bits");
endmodule : ppc_port_ctrl

// File: tb/test_port_phy_control_register.sv
// self-checking bench for the port phy control register bank
`timescale 1ns/100ps
module test_port_phy_control_register;
	import ppc_pkg::*;

	// one row: a write, then a read, with expected storage and read value
	typedef struct packed {
		logic [7:0]  wa;
		logic [15:0] wd;
		logic [15:0] cx;
		logic [7:0]  ra;
		logic [15:0] rx;
	} ppc_row_t;

	logic             mclk;
	logic             rst_b;
	logic [7:0]       addr;
	logic [15:0]      wdata;
	logic             wr_stb;
	logic             rd_stb;
	logic [15:0]      rdata;
	logic [3:0]       led_status;
	logic             an_failed;
	logic             an_speed_100;
	logic             an_full_duplex;
	logic [14:0]      outs;
	logic             an_restart;
	logic [15:0]      d;
	logic [15:0]      dut_ctrl_exp;
	int               errors;
	int               n_compared;
	ppc_row_t         rows [9] = '{
		'{8'hf6, 16'hffff, 16'hffff, 8'hf6, 16'hffff},
		'{8'hf6, 16'h0000, 16'h0000, 8'he4, 16'h0000},
		'{8'he4, 16'hffff, 16'he6e0, 8'he4, 16'h331b},
		'{8'hec, 16'hffff, 16'he6ff, 8'hec, 16'h05e1},
		'{8'hf6, 16'h1800, 16'h1800, 8'hec, 16'h0001},
		'{8'hf6, 16'h0615, 16'h0615, 8'hec, 16'h04a1},
		'{8'hf6, 16'h0240, 16'h0240, 8'he4, 16'h2010},
		'{8'hec, 16'h0100, 16'h0248, 8'hf6, 16'h0248},
		'{8'hf8, 16'hffff, 16'h0248, 8'hf8, 16'h0000}
	};

	ppc_port_ctrl dut (
		.mclk            (mclk),
		.rst_b           (rst_b),
		.addr            (addr),
		.wdata           (wdata),
		.wr_stb          (wr_stb),
		.rd_stb          (rd_stb),
		.rdata           (rdata),
		.led_status      (led_status),
		.an_failed       (an_failed),
		.an_speed_100    (an_speed_100),
		.an_full_duplex  (an_full_duplex),
		.port_led_out3   (outs[14]),
		.port_led_out2   (outs[13]),
		.port_led_out1   (outs[12]),
		.port_led_out0   (outs[11]),
		.tx_disable      (outs[10]),
		.an_enable       (outs[9]),
		.an_restart      (an_restart),
		.auto_x_en       (outs[8]),
		.mdix_forced     (outs[7]),
		.link_speed_100  (outs[6]),
		.link_full_duplex(outs[5]),
		.adv_pause       (outs[4]),
		.adv_100_full    (outs[3]),
		.adv_100_half    (outs[2]),
		.adv_10_full     (outs[1]),
		.adv_10_half     (outs[0])
	);

	// expected port outputs from the stored control word and the inputs
	function automatic logic [14:0] exp_outs(input logic [15:0] c,
		input logic [3:0] ls, input logic f, input logic sp, input logic fd);
		exp_outs = {{4{c[15]}} | ls, c[14], c[7], ~c[10], c[10] & c[9],
			c[7] ? sp : c[6], (c[7] && !f) ? fd : c[5], c[4:0]};
	endfunction : exp_outs

	task automatic chk(input string nm, input logic [15:0] exp,
		input logic [15:0] seen);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic chk_outs();
		chk("outputs", {1'b0, exp_outs(dut_ctrl_exp, led_status, an_failed,
			an_speed_100, an_full_duplex)}, {1'b0, outs});
	endtask : chk_outs

	// single-cycle write; returns after the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		addr   <= a;
		wdata  <= v;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : wr

	// single-cycle read; data are taken in the one cycle they stand
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge mclk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		v = rdata;
	endtask : rd

	// restart pulse stands exactly one cycle after the write edge
	task automatic pulse_chk(input logic [7:0] a, input logic [15:0] v,
		input logic p);
		wr(a, v);
		@(negedge mclk);
		chk("an_restart", {15'h0, p}, {15'h0, an_restart});
		@(negedge mclk);
		chk("an_restart low", 16'h0000, {15'h0, an_restart});
	endtask : pulse_chk

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		print_verdict();
	end

	initial begin : main
		rst_b = 1'b0; addr = 8'h00; wdata = 16'h0000; wr_stb = 1'b0;
		rd_stb = 1'b0; led_status = 4'h5; an_failed = 1'b0;
		an_speed_100 = 1'b0; an_full_duplex = 1'b0; dut_ctrl_exp = 16'h00ff;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		// ordinary cases: writes through every view, read back across views
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			dut_ctrl_exp = rows[i].cx;
			rd(rows[i].ra, d);
			chk("read", rows[i].rx, d);
			chk_outs();
		end
		$display("table test done");
		// restart: plain write of 0 gives none, each write of 1 pulses
		pulse_chk(8'hf6, 16'h0000, 1'b0);
		pulse_chk(8'hf6, 16'h2000, 1'b1);
		pulse_chk(8'he4, 16'h0200, 1'b1);
		pulse_chk(8'hf6, 16'h2000, 1'b1);
		pulse_chk(8'hec, 16'h2000, 1'b0);
		$display("restart test done");
		// write then read with no gap; read data gone the next cycle
		@(posedge mclk);
		addr <= 8'hf6; wdata <= 16'h4080; wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0; rd_stb <= 1'b1; addr <= 8'he4;
		@(posedge mclk);
		rd_stb <= 1'b0;
		dut_ctrl_exp = 16'h4080;
		@(negedge mclk);
		chk("b2b read", 16'h1002, rdata);
		@(negedge mclk);
		chk("rdata after", 16'h0000, rdata);
		chk_outs();
		$display("back to back test done");
		// negotiation on versus forced, leds normal versus blanked
		for (int j = 0; j < 2; j++) begin
			wr(8'hf6, j ? 16'h8040 : 16'h00a0);
			dut_ctrl_exp = j ? 16'h8040 : 16'h00a0;
			for (int k = 0; k < 16; k++) begin
				@(posedge mclk);
				{an_failed, an_speed_100, an_full_duplex} <= k[2:0];
				led_status <= ~k[3:0];
				repeat (2) @(posedge mclk);
				@(negedge mclk);
				chk_outs();
			end
		end
		$display("link and led test done");
		// reset in mid-run brings back every default
		@(posedge mclk);
		led_status <= 4'hf; an_failed <= 1'b0;
		an_speed_100 <= 1'b1; an_full_duplex <= 1'b1;
		@(posedge mclk);
		rst_b <= 1'b0;
		dut_ctrl_exp = 16'h00ff;
		@(negedge mclk);
		chk_outs();
		chk("an_restart reset", 16'h0000, {15'h0, an_restart});
		chk("rdata reset", 16'h0000, rdata);
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		rd(8'hf6, d);
		chk("ctrl reset", 16'h00ff, d);
		rd(8'he4, d);
		chk("basic reset", 16'h3100, d);
		rd(8'hec, d);
		chk("advert reset", 16'h05e1, d);
		$display("reset test done");
		print_verdict();
	end
endmodule : test_port_phy_control_register
